// [src/cpr_paged_regs.v]
// Paged register bank (addresses 8..15) of a one-port cable PHY with base register 7.
// Assumes a synchronous Avalon-MM master and synchronous status inputs from the port logic.
`timescale 1ns/10ps
`include "cpr_consts.vh"
`default_nettype none

// Operation
// - Page choice 0 selects port status page; port choice picks the port.
// - Unimplemented chosen port makes every port status location read zero.
// - Only port number 0 exists.
// - Pair A state: 11 high impedance, 01 one, 10 zero, 00 invalid.
// - Pair B state uses the same code mapping as pair A.
// - Child flag 1 for child; disconnected, disabled or suspended read child.
// - Child flag meaningless after bus reset until tree identification ends.
// - Connected flag sets only after 330 to 350 ms stable connection.
// - Hardware reset clears connected flag; bus reset leaves it.
// - Bias flag sets only after 41.6 to 52 us continuous bias.
// - Port-off control disables port; hardware reset clears; bus reset keeps.
// - Neighbor rate: 000 S100, 001 S200, 010 S400; others invalid.
// - Neighbor rate invalid after bus reset until self-identification completes.
// - Neighbor rate never reported above the S400 code.
// - Enabled port event sets event flag and notifies link; hardware reset clears enable.
// - Resume or suspend fault sets fault flag and suspends the port.
// - Writing 1 clears fault flag; hardware reset clears; bus reset keeps.
// - Page choice 1 selects the identification page.
// - Identification address 8 reads compliance level 01h.
// - 24-bit maker code at 10..12, most significant byte first.
// - 24-bit part code at 13..15, most significant byte first.
// - Page 7: link rate at 8, bridge capability at 9, rest test space.
// - 3-bit page choice in register 7 selects page; reset to zero.
// - Event flag sets on connected, bias, disable or fault change when enabled.
module cpr_paged_regs #(
    parameter [23:0] MAKER_CODE = 24'h123456,   // Arbitrary value
    parameter [23:0] PART_CODE  = 24'h654321,   // Arbitrary value
    parameter [31:0] CON_CYC    = `CPR_CON_CYC
) (
    input  wire        CLOCK_I,
    input  wire        RST_N_I,
    input  wire [5:0]  AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    input  wire [3:0]  AVS_BYTEENABLE_I,
    output reg  [31:0] AVS_READDATA_O,
    output reg         AVS_WAITREQUEST_O,
    input  wire [1:0]  PAIR_A_LINE_STATE_I,
    input  wire [1:0]  PAIR_B_LINE_STATE_I,
    input  wire        PORT_IS_CHILD_I,
    input  wire        CONNECT_RAW_I,
    input  wire        BIAS_RAW_I,
    input  wire [2:0]  PEER_RATE_I,
    input  wire        RESUMING_I,
    input  wire        SUSPENDING_I,
    input  wire        BRIDGE_STRAP_I,
    output reg         PORT_DISABLE_O,
    output reg         PORT_SUSPEND_O,
    output reg         PORT_EVENT_IRQ_FLAG_O,
    output reg         CONNECTED_O,
    output reg         BIAS_O
);

    reg  [2:0]  page_choice;
    reg  [3:0]  port_choice;
    reg         port_off;
    reg         port_event_irq_enable;
    reg         fault;
    reg  [1:0]  llc_rate;
    reg  [1:0]  bridge_report;
    reg         strap_done;
    reg  [31:0] con_cnt;
    reg  [15:0] bias_cnt;
    reg  [3:0]  prev_status;
    reg  [7:0]  rd_byte;

    wire [3:0]  index     = AVS_ADDRESS_I[5:2];
    // Writes land on the answering edge, the one where the master sees waitrequest low
    wire        wr_go     = AVS_WRITE_I & ~AVS_WAITREQUEST_O & AVS_BYTEENABLE_I[0];
    wire        rd_go     = AVS_READ_I & AVS_WAITREQUEST_O;
    wire        port_ok   = (port_choice == `CPR_ONLY_PORT);
    wire        on_port   = (page_choice == `CPR_PAGE_PORT) & port_ok;
    wire        wr_lo     = wr_go & (index == `CPR_IDX_LO);
    wire        wr_hi     = wr_go & (index == `CPR_IDX_HI);
    wire        resume_fault  = RESUMING_I & ~BIAS_O;
    wire        suspend_fault = SUSPENDING_I & BIAS_O;
    wire        fault_clr = wr_hi & on_port & AVS_WRITEDATA_I[`CPR_FAULT_BIT];
    wire        next_fault = (resume_fault | suspend_fault) ? 1'b1 : (fault_clr ? 1'b0 : fault);
    // Tree identification state is passed through as is; software waits for it to finish
    wire        child     = PORT_IS_CHILD_I | ~CONNECTED_O | port_off | PORT_SUSPEND_O;
    wire [2:0]  rate      = (PEER_RATE_I > `CPR_RATE_S400) ? `CPR_RATE_S400 : PEER_RATE_I;
    wire [3:0]  status    = {CONNECTED_O, BIAS_O, port_off, fault};
    wire        evt_clr   = wr_go & (index == `CPR_IDX_BASE7) & AVS_WRITEDATA_I[`CPR_EVT_BIT];

    // Avalon: one wait cycle, answer on the second edge of the request
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
        end else if ((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O) begin
            AVS_WAITREQUEST_O <= 1'b0;
        end else begin
            AVS_WAITREQUEST_O <= 1'b1;
        end
    end

    // Read mux; reserved and foreign-page locations read zero
    always @* begin
        rd_byte = 8'h00;
        if (index == `CPR_IDX_BASE7) begin
            rd_byte = {page_choice, PORT_EVENT_IRQ_FLAG_O, port_choice};
        end else if (page_choice == `CPR_PAGE_PORT) begin
            if (port_ok && index == `CPR_IDX_LO) begin
                rd_byte = {PAIR_A_LINE_STATE_I, PAIR_B_LINE_STATE_I, child,
                           CONNECTED_O, BIAS_O, port_off};
            end else if (port_ok && index == `CPR_IDX_HI) begin
                rd_byte = {rate, port_event_irq_enable, fault, 3'h0};
            end
        end else if (page_choice == `CPR_PAGE_IDENT) begin
            case (index)
                `CPR_IDX_LO:     rd_byte = `CPR_COMPLIANCE;
                `CPR_IDX_MK_HI:  rd_byte = MAKER_CODE[23:16];
                `CPR_IDX_MK_MID: rd_byte = MAKER_CODE[15:8];
                `CPR_IDX_MK_LO:  rd_byte = MAKER_CODE[7:0];
                `CPR_IDX_PT_HI:  rd_byte = PART_CODE[23:16];
                `CPR_IDX_PT_MID: rd_byte = PART_CODE[15:8];
                `CPR_IDX_PT_LO:  rd_byte = PART_CODE[7:0];
                default:         rd_byte = 8'h00;
            endcase
        end else if (page_choice == `CPR_PAGE_VENDOR) begin
            if (index == `CPR_IDX_LO) begin
                rd_byte = {6'h00, llc_rate};
            end else if (index == `CPR_IDX_HI) begin
                rd_byte = {6'h00, bridge_report};
            end
        end
    end

    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            AVS_READDATA_O <= 32'h0000_0000;
        end else if (rd_go) begin
            AVS_READDATA_O <= {24'h00_0000, rd_byte};
        end
    end

    // Software-written state
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            page_choice           <= `CPR_PAGE_PORT;
            port_choice           <= `CPR_ONLY_PORT;
            port_off              <= 1'b0;
            port_event_irq_enable <= 1'b0;
            llc_rate              <= `CPR_LINK_RATE_RST;
            bridge_report         <= `CPR_BRIDGE_OFF;
            strap_done            <= 1'b0;
        end else begin
            strap_done <= 1'b1;
            if (!strap_done) begin
                bridge_report <= BRIDGE_STRAP_I ? `CPR_BRIDGE_ON : `CPR_BRIDGE_OFF;
            end
            if (wr_go && index == `CPR_IDX_BASE7) begin
                page_choice <= AVS_WRITEDATA_I[`CPR_PAGE_MSB:`CPR_PAGE_LSB];
                port_choice <= AVS_WRITEDATA_I[`CPR_PORT_MSB:`CPR_PORT_LSB];
            end
            if (wr_lo && on_port) begin
                port_off <= AVS_WRITEDATA_I[`CPR_DIS_BIT];
            end
            if (wr_hi && on_port) begin
                port_event_irq_enable <= AVS_WRITEDATA_I[`CPR_PIE_BIT];
            end
            if (wr_lo && page_choice == `CPR_PAGE_VENDOR) begin
                llc_rate <= AVS_WRITEDATA_I[1:0];
            end
            if (wr_hi && page_choice == `CPR_PAGE_VENDOR) begin
                bridge_report <= AVS_WRITEDATA_I[1:0];
            end
        end
    end

    // Debounce, fault and event state
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            con_cnt               <= 32'h0000_0000;
            bias_cnt              <= 16'h0000;
            CONNECTED_O           <= 1'b0;
            BIAS_O                <= 1'b0;
            fault                 <= 1'b0;
            PORT_SUSPEND_O        <= 1'b0;
            PORT_DISABLE_O        <= 1'b0;
            PORT_EVENT_IRQ_FLAG_O <= 1'b0;
            prev_status           <= 4'h0;
        end else begin
            // Connection must hold the full window; any drop restarts it
            if (!CONNECT_RAW_I) begin
                con_cnt     <= 32'h0000_0000;
                CONNECTED_O <= 1'b0;
            end else if (con_cnt >= CON_CYC - 32'h1) begin
                CONNECTED_O <= 1'b1;
            end else begin
                con_cnt <= con_cnt + 32'h1;
            end
            if (!BIAS_RAW_I) begin
                bias_cnt <= 16'h0000;
                BIAS_O   <= 1'b0;
            end else if ({16'h0000, bias_cnt} >= `CPR_BIAS_CYC - 1) begin
                BIAS_O <= 1'b1;
            end else begin
                bias_cnt <= bias_cnt + 16'h1;
            end
            fault <= next_fault;
            if (resume_fault | suspend_fault) begin
                PORT_SUSPEND_O <= 1'b1;
            end else if (RESUMING_I) begin
                PORT_SUSPEND_O <= 1'b0;
            end
            PORT_DISABLE_O <= port_off;
            prev_status    <= status;
            // Set beats the write-one clear
            if (port_event_irq_enable && (status != prev_status)) begin
                PORT_EVENT_IRQ_FLAG_O <= 1'b1;
            end else if (evt_clr) begin
                PORT_EVENT_IRQ_FLAG_O <= 1'b0;
            end
        end
    end

endmodule // cpr_paged_regs
`default_nettype wire

// [src/cpr_consts.vh]
// Constants of the paged register bank: offsets, fields, resets, timing.
// Assumes inclusion by its bare name from the design file only.
`ifndef CPR_CONSTS_VH
`define CPR_CONSTS_VH
// Avalon word index of each register; byte address is four times the index
`define CPR_IDX_BASE7      4'h7
`define CPR_IDX_LO         4'h8
`define CPR_IDX_HI         4'h9
`define CPR_IDX_MK_HI      4'ha
`define CPR_IDX_MK_MID     4'hb
`define CPR_IDX_MK_LO      4'hc
`define CPR_IDX_PT_HI      4'hd
`define CPR_IDX_PT_MID     4'he
`define CPR_IDX_PT_LO      4'hf
// Page choice codes
`define CPR_PAGE_PORT      3'h0
`define CPR_PAGE_IDENT     3'h1
`define CPR_PAGE_VENDOR    3'h7
// Base register 7 layout: page choice in [7:5], port choice in [3:0]
`define CPR_PAGE_MSB       7
`define CPR_PAGE_LSB       5
`define CPR_PORT_MSB       3
`define CPR_PORT_LSB       0
`define CPR_ONLY_PORT      4'h0
// Port status page field positions (bit 7 is the msb, bit 0 of the table)
`define CPR_DIS_BIT        0
`define CPR_BIAS_BIT       1
`define CPR_CON_BIT        2
`define CPR_CH_BIT         3
`define CPR_FAULT_BIT      3
`define CPR_PIE_BIT        4
`define CPR_EVT_BIT        4
// Neighbor rate codes
`define CPR_RATE_S400      3'h2
// Reset values
`define CPR_COMPLIANCE     8'h01
`define CPR_LINK_RATE_RST  2'h2
`define CPR_BRIDGE_ON      2'h3
`define CPR_BRIDGE_OFF     2'h0
// Debounce windows in their own units and derived cycle counts at 20 MHz
`define CPR_CLK_HZ         20000000
`define CPR_CON_MS         330
`define CPR_CON_CYC        (`CPR_CON_MS * (`CPR_CLK_HZ / 1000))
`define CPR_BIAS_NS        41600
`define CPR_BIAS_CYC       ((`CPR_BIAS_NS * (`CPR_CLK_HZ / 1000000) + 999) / 1000)
`endif

// [sim/cpr_checker.sv]
// Concurrent checks on the paged register bank ports.
// Assumes binding into cpr_paged_regs, taking over its CON_CYC value.
`timescale 1ns/10ps
`default_nettype none
module cpr_checker #(
    parameter int CON_CYC = 20
) (
    input wire logic        CLOCK_I,
    input wire logic        RST_N_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic        CONNECT_RAW_I,
    input wire logic        BIAS_RAW_I,
    input wire logic        RESUMING_I,
    input wire logic        SUSPENDING_I,
    input wire logic        PORT_DISABLE_O,
    input wire logic        PORT_SUSPEND_O,
    input wire logic        PORT_EVENT_IRQ_FLAG_O,
    input wire logic        CONNECTED_O,
    input wire logic        BIAS_O
);
    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);
    logic [31:0] con_run;
    logic [31:0] bias_run;
    logic [2:0]  chg_hist;
    wire  [3:0]  cause = {CONNECTED_O, BIAS_O, PORT_DISABLE_O, PORT_SUSPEND_O};
    // Run lengths of the raw levels, so debounce windows can be judged
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            con_run  <= 32'h0;
            bias_run <= 32'h0;
            chg_hist <= 3'h0;
        end else begin
            con_run  <= CONNECT_RAW_I ? con_run + 32'h1 : 32'h0;
            bias_run <= BIAS_RAW_I ? bias_run + 32'h1 : 32'h0;
            chg_hist <= {chg_hist[1:0], $changed(cause)};
        end
    end
    sequence taken_s;
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
    endsequence
    sequence answer_s;
        !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
    endsequence
    answer_once_a: assert property (taken_s |=> answer_s)
        else $error("access not answered in one cycle");
    con_min_wait_a: assert property ($rose(CONNECTED_O) |-> con_run >= CON_CYC)
        else $error("connected flag set before debounce");
    con_max_wait_a: assert property (con_run == CON_CYC + 4 |-> CONNECTED_O)
        else $error("connected flag late");
    bias_min_wait_a: assert property ($rose(BIAS_O) |-> bias_run >= 832)
        else $error("bias flag set before debounce");
    bias_max_wait_a: assert property (bias_run == 1040 |-> BIAS_O)
        else $error("bias flag late");
    dis_by_write_a: assert property ($changed(PORT_DISABLE_O) |-> $past(AVS_WRITE_I, 2))
        else $error("port disable moved without a write");
    event_cause_a: assert property ($rose(PORT_EVENT_IRQ_FLAG_O) |-> ##[0:2] chg_hist != 3'h0)
        else $error("port event without a status change");
    fault_cause_a: assert property ($rose(PORT_SUSPEND_O) |->
        $past(RESUMING_I) || $past(SUSPENDING_I) || $past(RESUMING_I, 2) || $past(SUSPENDING_I, 2))
        else $error("suspend without resume or suspend activity");
endmodule // cpr_checker
bind cpr_paged_regs cpr_checker #(.CON_CYC(CON_CYC)) i_chk (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CONNECT_RAW_I(CONNECT_RAW_I), .BIAS_RAW_I(BIAS_RAW_I),
    .RESUMING_I(RESUMING_I), .SUSPENDING_I(SUSPENDING_I), .PORT_DISABLE_O(PORT_DISABLE_O),
    .PORT_SUSPEND_O(PORT_SUSPEND_O), .PORT_EVENT_IRQ_FLAG_O(PORT_EVENT_IRQ_FLAG_O),
    .CONNECTED_O(CONNECTED_O), .BIAS_O(BIAS_O));
`default_nettype wire

// [sim/cpr_llc_model.sv]
// Link-layer controller model: byte register accesses over Avalon-MM.
// Assumes a slave that lowers waitrequest once per accepted request.
`timescale 1ns/10ps
`default_nettype none
module cpr_llc_model (
    input  wire logic        clk_i,
    input  wire logic        wait_i,
    input  wire logic [31:0] rdata_i,
    output var  logic [5:0]  addr_o,
    output var  logic        read_o,
    output var  logic        write_o,
    output var  logic [31:0] wdata_o,
    output var  logic        stuck_o
);
    initial begin
        addr_o  = 6'h0;
        read_o  = 1'b0;
        write_o = 1'b0;
        wdata_o = 32'h0;
        stuck_o = 1'b0;
    end
    // Leading edge keeps a new request off the edge that released the last
    task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        addr_o  <= {idx, 2'h0};
        wdata_o <= {24'h0, d};
        read_o  <= !w;
        write_o <= w;
        do begin
            @(posedge clk_i);
            n++;
        end while (wait_i !== 1'b0 && n < 64);
        q = rdata_i[7:0];
        read_o  <= 1'b0;
        write_o <= 1'b0;
        if (wait_i !== 1'b0)
            stuck_o <= 1'b1;
    endtask
    // Child and peer rate are only read with no bus reset pending
    task automatic sel(input logic [2:0] pg, input logic [3:0] port);
        logic [7:0] q;
        xfer(1'b1, 4'h7, {pg, 1'b0, port}, q);
    endtask
endmodule // cpr_llc_model
`default_nettype wire

// [sim/tb_cable_phy_paged_registers.sv]
// Self-checking bench for the paged register bank.
// Assumes the link-layer model as bus master and a 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_cable_phy_paged_registers;
    localparam int          CON   = 20;
    localparam logic [47:0] IDS   = 48'h3c5a96_a5c3e1; // Arbitrary maker and part values
    logic        clk, rst_n, rd, wr, waitreq, stuck, child, con_raw;
    logic        bias_raw, resuming, suspending, dis, susp, irq, con, bias;
    logic [1:0]  pa, pb;
    logic [2:0]  rate;
    logic [5:0]  addr;
    logic [7:0]  q;
    logic [31:0] wdata, rdata;
    int          n_errors, comparisons;
    cpr_paged_regs #(.MAKER_CODE(IDS[47:24]), .PART_CODE(IDS[23:0]), .CON_CYC(32'(CON))) i_dut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .PAIR_A_LINE_STATE_I(pa), .PAIR_B_LINE_STATE_I(pb), .PORT_IS_CHILD_I(child), .CONNECT_RAW_I(con_raw),
        .BIAS_RAW_I(bias_raw), .PEER_RATE_I(rate), .RESUMING_I(resuming), .SUSPENDING_I(suspending),
        .BRIDGE_STRAP_I(1'b1), .PORT_DISABLE_O(dis), .PORT_SUSPEND_O(susp), .PORT_EVENT_IRQ_FLAG_O(irq),
        .CONNECTED_O(con), .BIAS_O(bias));
    cpr_llc_model i_llc (.clk_i(clk), .wait_i(waitreq), .rdata_i(rdata), .addr_o(addr), .read_o(rd),
        .write_o(wr), .wdata_o(wdata), .stuck_o(stuck));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
        i_llc.xfer(1'b0, idx, 8'h0, q);
        chk(q, exp);
    endtask
    task automatic t_ident();
        i_llc.sel(3'h1, 4'h0);
        i_llc.xfer(1'b1, 4'h8, 8'hff, q);
        rdc(4'h8, 8'h01);
        rdc(4'h9, 8'h00);
        for (int i = 0; i < 6; i++)
            rdc(4'ha + 4'(i), IDS[47 - 8 * i -: 8]);
        rdc(4'h2, 8'h00);
        $display("test ident done");
    endtask
    task automatic t_port();
        i_llc.sel(3'h0, 4'h0);
        // Disconnected port must read as child whatever the input says
        for (int i = 0; i < 4; i++) begin
            pa <= 2'(i);
            pb <= 2'(3 - i);
            child <= i[0];
            rdc(4'h8, {2'(i), 2'(3 - i), 4'h8});
        end
        child <= 1'b0;
        for (int r = 0; r < 8; r++) begin
            rate <= 3'(r);
            rdc(4'h9, {(r > 2) ? 3'h2 : 3'(r), 5'h0});
        end
        rdc(4'hb, 8'h00);
        i_llc.sel(3'h0, 4'h1);
        rdc(4'h8, 8'h00);
        rdc(4'h9, 8'h00);
        $display("test port status done");
    endtask
    task automatic t_link();
        i_llc.sel(3'h0, 4'h0);
        con_raw <= 1'b1;
        repeat (CON - 3) @(posedge clk);
        chk({7'h0, con}, 8'h00);
        repeat (6) @(posedge clk);
        chk({7'h0, con}, 8'h01);
        bias_raw <= 1'b1;
        repeat (820) @(posedge clk);
        chk({7'h0, bias}, 8'h00);
        repeat (225) @(posedge clk);
        chk({7'h0, bias}, 8'h01);
        rdc(4'h8, 8'hc6);
        i_llc.xfer(1'b1, 4'h9, 8'h10, q);
        i_llc.xfer(1'b1, 4'h8, 8'h01, q);
        repeat (3) @(posedge clk);
        chk({6'h0, dis, irq}, 8'h03);
        rdc(4'h8, 8'hcf);
        rdc(4'h7, 8'h10);
        i_llc.xfer(1'b1, 4'h7, 8'h10, q);
        rdc(4'h7, 8'h00);
        i_llc.xfer(1'b1, 4'h8, 8'h00, q);
        $display("test link status done");
    endtask
    task automatic t_fault();
        bias_raw <= 1'b0;
        resuming <= 1'b1;
        repeat (4) @(posedge clk);
        resuming <= 1'b0;
        chk({7'h0, susp}, 8'h01);
        rdc(4'h9, 8'h58);
        i_llc.xfer(1'b1, 4'h9, 8'h18, q);
        rdc(4'h9, 8'h50);
        // Resume with bias present leaves suspend; a suspend that still sees bias faults
        bias_raw <= 1'b1;
        repeat (840) @(posedge clk);
        resuming <= 1'b1;
        repeat (2) @(posedge clk);
        resuming <= 1'b0;
        suspending <= 1'b1;
        chk({7'h0, susp}, 8'h00);
        repeat (2) @(posedge clk);
        suspending <= 1'b0;
        chk({7'h0, susp}, 8'h01);
        rdc(4'h9, 8'h58);
        $display("test fault done");
    endtask
    task automatic t_vendor();
        i_llc.sel(3'h7, 4'h0);
        rdc(4'h8, 8'h02);
        i_llc.xfer(1'b1, 4'h8, 8'h03, q);
        rdc(4'h8, 8'h03);
        rdc(4'h9, 8'h03);
        i_llc.xfer(1'b1, 4'h9, 8'h01, q);
        rdc(4'h9, 8'h01);
        rdc(4'hc, 8'h00);
        $display("test vendor page done");
    endtask
    task automatic t_reset();
        i_llc.sel(3'h0, 4'h0);
        i_llc.xfer(1'b1, 4'h8, 8'h01, q);
        repeat (2) @(posedge clk);
        chk({6'h0, con, dis}, 8'h03);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk({6'h0, con, dis}, 8'h00);
        rdc(4'h7, 8'h00);
        rdc(4'h9, 8'h40);
        i_llc.sel(3'h7, 4'h0);
        rdc(4'h8, 8'h02);
        $display("test hardware reset done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge stuck) begin
        n_errors++;
        report_and_stop();
    end
    initial begin
        {rst_n, child, con_raw, bias_raw, resuming, suspending, pa, pb, rate} = '0;
        n_errors = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_ident();
        t_port();
        t_link();
        t_fault();
        t_vendor();
        t_reset();
        report_and_stop();
    end
endmodule // tb_cable_phy_paged_registers
`default_nettype wire
